/* hdl/dsc_pkg.sv */
/*
 * dsc_pkg: register indices, reset values, field positions and sync
 * source codes of the start-up configuration register file.
 * Assumes each 16-bit register sits in one aligned 32-bit APB word.
 */
package dsc_pkg;

    // data and address widths
    localparam int REG_W  = 16;
    localparam int IDX_W  = 6;
    localparam int NREG   = 21;
    localparam int SLOT_W = 5;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CORE_FEATURE_CONTROL      = 6'h00;
    localparam logic [IDX_W-1:0] IDX_PARITY_ALARM_ENABLE       = 6'h01;
    localparam logic [IDX_W-1:0] IDX_OUTPUT_SHUTOFF_MIXER_CTRL = 6'h02;
    localparam logic [IDX_W-1:0] IDX_OUTPUT_CURRENT_CTRL       = 6'h03;
    localparam logic [IDX_W-1:0] IDX_ALARM_FLAGS               = 6'h05;
    localparam logic [IDX_W-1:0] IDX_ALARM_OUTPUT_MASK         = 6'h07;
    localparam logic [IDX_W-1:0] IDX_CHAN_I_OFFSET_CORR        = 6'h08;
    localparam logic [IDX_W-1:0] IDX_FIFO_AND_CHAN_Q_OFFSET    = 6'h09;
    localparam logic [IDX_W-1:0] IDX_CHAN_I_GAIN_CORR          = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_CHAN_Q_GAIN_COARSE_MIX    = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_IQ_PHASE_CORR             = 6'h10;
    localparam logic [IDX_W-1:0] IDX_NCO_PHASE_OFFSET          = 6'h12;
    localparam logic [IDX_W-1:0] IDX_NCO_FREQ_UPPER            = 6'h14;
    localparam logic [IDX_W-1:0] IDX_NCO_FREQ_LOWER            = 6'h15;
    localparam logic [IDX_W-1:0] IDX_PLL_MAIN_CTRL             = 6'h18;
    localparam logic [IDX_W-1:0] IDX_PLL_DIVIDER_CTRL          = 6'h19;
    localparam logic [IDX_W-1:0] IDX_PLL_VCO_TUNE              = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_REFERENCE_SELECT          = 6'h1b;
    localparam logic [IDX_W-1:0] IDX_QMC_SYNC_SOURCE           = 6'h1e;
    localparam logic [IDX_W-1:0] IDX_MIXER_FORMATTER_SYNC_SRC  = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_FIFO_CLKDIV_SYNC_SOURCE   = 6'h20;

    // storage slot of each register, in the order above
    localparam logic [IDX_W-1:0] REG_IDX [NREG] = '{
        IDX_CORE_FEATURE_CONTROL, IDX_PARITY_ALARM_ENABLE, IDX_OUTPUT_SHUTOFF_MIXER_CTRL,
        IDX_OUTPUT_CURRENT_CTRL, IDX_ALARM_FLAGS, IDX_ALARM_OUTPUT_MASK,
        IDX_CHAN_I_OFFSET_CORR, IDX_FIFO_AND_CHAN_Q_OFFSET, IDX_CHAN_I_GAIN_CORR,
        IDX_CHAN_Q_GAIN_COARSE_MIX, IDX_IQ_PHASE_CORR, IDX_NCO_PHASE_OFFSET,
        IDX_NCO_FREQ_UPPER, IDX_NCO_FREQ_LOWER, IDX_PLL_MAIN_CTRL, IDX_PLL_DIVIDER_CTRL,
        IDX_PLL_VCO_TUNE, IDX_REFERENCE_SELECT, IDX_QMC_SYNC_SOURCE,
        IDX_MIXER_FORMATTER_SYNC_SRC, IDX_FIFO_CLKDIV_SYNC_SOURCE
    };

    // reset values
    localparam logic [REG_W-1:0] RST_CORE_FEATURE = 16'h049c;
    localparam logic [REG_W-1:0] RST_PARITY_ALARM = 16'h050e;
    localparam logic [REG_W-1:0] RST_SHUTOFF_MIX  = 16'h7000;
    localparam logic [REG_W-1:0] RST_CURRENT      = 16'hf000;
    localparam logic [REG_W-1:0] RST_ALARM_MASK   = 16'hffff;
    localparam logic [REG_W-1:0] RST_Q_OFFSET     = 16'h8000;
    localparam logic [REG_W-1:0] RST_GAIN         = 16'h0400;
    localparam logic [REG_W-1:0] RST_ZERO         = 16'h0000;

    localparam logic [REG_W-1:0] REG_RST [NREG] = '{
        RST_CORE_FEATURE, RST_PARITY_ALARM, RST_SHUTOFF_MIX, RST_CURRENT, RST_ZERO,
        RST_ALARM_MASK, RST_ZERO, RST_Q_OFFSET, RST_GAIN, RST_GAIN, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO
    };

    // slots that the logic reads directly
    localparam int S_CORE     = 0;
    localparam int S_SHUTOFF  = 2;
    localparam int S_CURRENT  = 3;
    localparam int S_ALARMS   = 4;
    localparam int S_MASK     = 5;
    localparam int S_FREQ_UP  = 12;
    localparam int S_FREQ_LO  = 13;
    localparam int S_PLL_MAIN = 14;
    localparam int S_MIXSYNC  = 19;
    localparam int S_FIFOSYNC = 20;

    // field positions
    localparam int B_CLKDIV_SYNC_ENA = 2;
    localparam int B_ALARM_POL       = 3;
    localparam int B_ALARM_OUT_ENA   = 4;
    localparam int B_SIF_TXENABLE    = 0;
    localparam int B_SIF_SYNC        = 1;
    localparam int B_PLL_NDIVSYNC    = 11;
    localparam int B_CLKDIV_SEL      = 0;
    localparam int B_SHUT_DACCLK     = 14;
    localparam int B_SHUT_DATACLK    = 13;
    localparam int B_SHUT_COLLISION  = 12;
    localparam int B_ALM_COLLISION   = 13;
    localparam int B_ALM_DACCLK      = 10;
    localparam int B_ALM_DATACLK     = 9;
    localparam int FMT_LSB           = 2;
    localparam int FIFOIN_LSB        = 12;
    localparam int FIFOOUT_LSB       = 8;
    localparam int LFVOLT_W          = 3;

    // sync source codes; a nibble is a mask of sources
    localparam logic [3:0] SEL_SYNC  = 4'h1;
    localparam logic [3:0] SEL_FRAME = 4'h2;
    localparam logic [3:0] SEL_DIVIDER_OUTPUT_STROBE  = 4'h4;
    localparam logic [1:0] FMT_FRAME = 2'h0;
    localparam logic [1:0] FMT_SYNC  = 2'h1;
    localparam logic       CLKDIV_FROM_DIVIDER_OUTPUT_STROBE = 1'b0;

    // apb answer
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

endpackage

/* hdl/dsc_edge_detect.sv */
/*
 * dsc_edge_detect: registered rising-edge detector, one per strobe.
 * Assumes the strobes are already synchronous to core_clk.
 */
`timescale 1ns/1ns
module dsc_edge_detect #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // strobes in, one-cycle rise pulses out
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] rise;
    } dsc_edge_t;

    dsc_edge_t st;
    dsc_edge_t next_st;

    // one lane per strobe
    always_comb begin
        next_st = st;
        for (int i = 0; i < W; i++) begin
            next_st.rise[i] = level[i] & ~st.prev[i];
            next_st.prev[i] = level[i];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise = st.rise;
endmodule

/* hdl/dsc_alarm_latch.sv */
/*
 * dsc_alarm_latch: sticky alarm bits, set by hardware events, cleared
 * by a register write (bits written as zero clear).
 * Assumes clr_strobe is a one-cycle pulse with clr_data valid.
 */
`timescale 1ns/1ns
module dsc_alarm_latch #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // hardware events
    input  wire logic [W-1:0] set_evt,
    // software clear
    input  wire logic         clr_strobe,
    input  wire logic [W-1:0] clr_data,
    // latched flags
    output logic      [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } dsc_alarm_t;

    dsc_alarm_t st;
    dsc_alarm_t next_st;

    // an event in the clear cycle survives: the set is or-ed in last
    always_comb begin
        next_st = st;
        if (clr_strobe) begin
            next_st.flags = st.flags & clr_data;
        end
        next_st.flags = next_st.flags | set_evt;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
endmodule

/* hdl/dsc_config_regs.sv */
/*
 * dsc_config_regs: configuration register file of a dual-channel DAC,
 * reached over APB, with the sync side effects of register writes and
 * of the sync, frame and divider strobes.
 * Assumes all pins are synchronous to core_clk; arst_n is the device
 * reset pin.
 */
// The APB register port was decided locally.
// Behaviour
// - NCO syncs on sync strobe rising edge
// - I offset write resyncs offset correction
// - phase write resyncs correction; host sets bits
// - phase offset write resyncs NCO mixer
// - writing zero clears all latched alarms
// - software sync bit syncs all corrections
`timescale 1ns/1ns
module dsc_config_regs #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           arst_n,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ADDR_W-1:0]              paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // device pins and status inputs
    input  wire logic                           transmit_gate,
    input  wire logic                           sync_strobe,
    input  wire logic                           frame_strobe,
    input  wire logic                           divider_output_strobe,
    input  wire logic [dsc_pkg::REG_W-1:0]      alarm_events,
    input  wire logic [dsc_pkg::LFVOLT_W-1:0]   pll_loop_voltage,
    // sync pulses to the datapath
    output logic                                qmc_offset_sync,
    output logic                                qmc_corr_sync,
    output logic                                nco_mixer_sync,
    output logic                                nco_accum_sync,
    output logic                                formatter_sync,
    output logic                                fifo_in_ptr_sync,
    output logic                                fifo_out_ptr_sync,
    output logic                                clkdiv_sync,
    output logic                                pll_ndiv_sync,
    // configuration and status outputs
    output logic [31:0]                         nco_freq_word_ab,
    output logic [dsc_pkg::REG_W-1:0]           feature_control,
    output logic [dsc_pkg::REG_W-1:0]           current_control,
    output logic                                alarm_out,
    output logic                                tx_active,
    output logic                                output_mute
);
    import dsc_pkg::*;

    typedef struct packed {
        logic [NREG-1:0][REG_W-1:0] regs;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
        logic                       qmc_offset_sync;
        logic                       qmc_corr_sync;
        logic                       nco_mixer_sync;
        logic                       nco_accum_sync;
        logic                       formatter_sync;
        logic                       fifo_in_ptr_sync;
        logic                       fifo_out_ptr_sync;
        logic                       clkdiv_sync;
        logic                       pll_ndiv_sync;
        logic [31:0]                freq_word;
        logic                       alarm_out;
        logic                       tx_active;
        logic                       output_mute;
    } dsc_state_t;

    dsc_state_t st;
    dsc_state_t next_st;

    logic [2:0]       strobe_rise;
    logic [REG_W-1:0] alarm_flags;
    logic             alarm_clr;

    // address decode for the current request
    logic             hit;
    logic [SLOT_W-1:0] slot;
    logic [IDX_W-1:0] req_idx;
    logic             wr_commit;

    assign req_idx = paddr[IDX_W+1:2];

    always_comb begin
        hit  = 1'b0;
        slot = '0;
        for (int i = 0; i < NREG; i++) begin
            if (paddr[1:0] == 2'h0 && req_idx == REG_IDX[i]) begin
                hit  = 1'b1;
                slot = SLOT_W'(i);
            end
        end
    end

    // a write lands only on the edge that also ends the access phase
    assign wr_commit = psel & penable & pwrite & st.pready & hit;
    assign alarm_clr = wr_commit & (slot == SLOT_W'(S_ALARMS));

    // strobe lanes: 0 sync, 1 frame, 2 divider output
    dsc_edge_detect #(
        .W (3)
    ) u_edges (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .level    ({divider_output_strobe, frame_strobe, sync_strobe}),
        .rise     (strobe_rise)
    );

    dsc_alarm_latch #(
        .W (REG_W)
    ) u_alarms (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .set_evt    (alarm_events),
        .clr_strobe (alarm_clr),
        .clr_data   (pwdata[REG_W-1:0]),
        .flags      (alarm_flags)
    );

    // next state: bus slave, register writes and their sync side effects
    always_comb begin
        logic             sw_sync_rise;
        logic [REG_W-1:0] core;
        logic [REG_W-1:0] mix;
        logic [REG_W-1:0] fifo;
        logic [REG_W-1:0] rd;
        logic             alarm_act;
        logic             tx_on;
        sw_sync_rise = 1'b0;
        core         = st.regs[S_CORE];
        mix          = st.regs[S_MIXSYNC];
        fifo         = st.regs[S_FIFOSYNC];
        rd           = RST_ZERO;
        alarm_act    = 1'b0;
        tx_on        = 1'b0;
        next_st      = st;

        // one access cycle: answer prepared in setup
        next_st.pready  = psel & ~penable;
        next_st.pslverr = psel & ~penable & ~hit;
        next_st.prdata  = RDATA_NONE;
        if (psel && !penable && hit) begin
            rd = st.regs[slot];
            if (slot == SLOT_W'(S_ALARMS)) begin
                rd = alarm_flags;
            end
            if (slot == SLOT_W'(S_PLL_MAIN)) begin
                rd[LFVOLT_W-1:0] = pll_loop_voltage;
            end
            next_st.prdata = {16'h0000, rd};
        end

        // write-triggered resyncs default low
        next_st.qmc_offset_sync = 1'b0;
        next_st.qmc_corr_sync   = 1'b0;
        next_st.nco_mixer_sync  = 1'b0;
        if (wr_commit && slot != SLOT_W'(S_ALARMS)) begin
            next_st.regs[slot] = pwdata[REG_W-1:0];
            // 0-to-1 step syncs; clear to re-arm
            if (slot == SLOT_W'(S_MIXSYNC)) begin
                sw_sync_rise = pwdata[B_SIF_SYNC] & ~mix[B_SIF_SYNC];
            end
            if (req_idx == IDX_CHAN_I_OFFSET_CORR) begin
                next_st.qmc_offset_sync = 1'b1;
            end
            if (req_idx == IDX_IQ_PHASE_CORR) begin
                next_st.qmc_corr_sync = 1'b1;
            end
            if (req_idx == IDX_NCO_PHASE_OFFSET) begin
                next_st.nco_mixer_sync = 1'b1;
            end
        end
        if (sw_sync_rise) begin
            next_st.qmc_offset_sync = 1'b1;
            next_st.qmc_corr_sync   = 1'b1;
        end

        // 32-bit word assembled from the two halves
        next_st.freq_word = {st.regs[S_FREQ_UP], st.regs[S_FREQ_LO]};

        // strobe-driven syncs; all but nco_accum_sync qualified by a selection or enable bit
        next_st.nco_accum_sync = strobe_rise[0];
        next_st.formatter_sync =
            (mix[FMT_LSB+:2] == FMT_FRAME && strobe_rise[1]) ||
            (mix[FMT_LSB+:2] == FMT_SYNC && strobe_rise[0]);
        // source mask bits line up with the strobe lanes
        next_st.fifo_in_ptr_sync  = |(fifo[FIFOIN_LSB+:4] & {1'b0, strobe_rise});
        next_st.fifo_out_ptr_sync = |(fifo[FIFOOUT_LSB+:4] & {1'b0, strobe_rise});
        next_st.clkdiv_sync = core[B_CLKDIV_SYNC_ENA] &&
            ((fifo[B_CLKDIV_SEL] == CLKDIV_FROM_DIVIDER_OUTPUT_STROBE) ? strobe_rise[2] : strobe_rise[1]);
        next_st.pll_ndiv_sync = st.regs[S_PLL_MAIN][B_PLL_NDIVSYNC] && strobe_rise[0];

        // alarm pin: unmasked latched alarms, polarity selectable
        alarm_act = |(alarm_flags & ~st.regs[S_MASK]) & core[B_ALARM_OUT_ENA];
        next_st.alarm_out = core[B_ALARM_POL] ? alarm_act : ~alarm_act;

        // transmit enable from pin or register bit
        tx_on = transmit_gate | st.regs[S_CURRENT][B_SIF_TXENABLE];
        next_st.tx_active = tx_on;
        // mute holds until software clears the flag
        next_st.output_mute = ~tx_on |
            (st.regs[S_SHUTOFF][B_SHUT_DACCLK] & alarm_flags[B_ALM_DACCLK]) |
            (st.regs[S_SHUTOFF][B_SHUT_DATACLK] & alarm_flags[B_ALM_DATACLK]) |
            (st.regs[S_SHUTOFF][B_SHUT_COLLISION] & alarm_flags[B_ALM_COLLISION]);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st             <= '0;
            st.output_mute <= 1'b1;
            for (int i = 0; i < NREG; i++) begin
                st.regs[i] <= REG_RST[i];
            end
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign prdata            = st.prdata;
    assign pready            = st.pready;
    assign pslverr           = st.pslverr;
    assign qmc_offset_sync   = st.qmc_offset_sync;
    assign qmc_corr_sync     = st.qmc_corr_sync;
    assign nco_mixer_sync    = st.nco_mixer_sync;
    assign nco_accum_sync    = st.nco_accum_sync;
    assign formatter_sync    = st.formatter_sync;
    assign fifo_in_ptr_sync  = st.fifo_in_ptr_sync;
    assign fifo_out_ptr_sync = st.fifo_out_ptr_sync;
    assign clkdiv_sync       = st.clkdiv_sync;
    assign pll_ndiv_sync     = st.pll_ndiv_sync;
    assign nco_freq_word_ab  = st.freq_word;
    assign feature_control   = st.regs[S_CORE];
    assign current_control   = st.regs[S_CURRENT];
    assign alarm_out         = st.alarm_out;
    assign tx_active         = st.tx_active;
    assign output_mute       = st.output_mute;
endmodule

/* testbench/dsc_config_properties.sv */
/* dsc_config_props: port-level timing checks of the config register file.
 * Assumes it is bound into dsc_config_regs; one clock, async reset. */
`timescale 1ns/1ns
module dsc_config_props #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic                      core_clk,
    input wire logic                      arst_n,
    // apb
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [ADDR_W-1:0]         paddr,
    input wire logic [31:0]               pwdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // pins and results
    input wire logic                      sync_strobe,
    input wire logic [dsc_pkg::REG_W-1:0] alarm_events,
    input wire logic                      qmc_offset_sync,
    input wire logic                      qmc_corr_sync,
    input wire logic                      nco_mixer_sync,
    input wire logic                      nco_accum_sync,
    input wire logic [31:0]               nco_freq_word_ab,
    input wire logic [dsc_pkg::REG_W-1:0] feature_control,
    input wire logic                      alarm_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // a write that takes effect at this edge
    logic commit;
    logic sw_q;
    assign commit = psel && penable && pready && pwrite;

    // last written software sync bit; its register resets to zero
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_q <= 1'b0;
        end else if (commit && paddr == 8'h7c) begin
            sw_q <= pwdata[1];
        end
    end

    // clear write with quiet events for two edges, active-high alarm pin
    sequence clear_s;
        commit && paddr == 8'h14 && pwdata[15:0] == 16'h0000 && alarm_events == '0
            && feature_control[3] ##1 alarm_events == '0;
    endsequence

    answer_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    refuse_unmapped_a: assert property (psel && penable && pready && paddr == 8'h10 |-> pslverr)
        else $error("unmapped access not refused");
    offset_resync_a: assert property (commit && paddr == 8'h20 |=> qmc_offset_sync)
        else $error("offset sync pulse missing");
    corr_resync_a: assert property (commit && paddr == 8'h40 |=> qmc_corr_sync)
        else $error("correction sync pulse missing");
    mixer_resync_a: assert property (commit && paddr == 8'h48 |=> nco_mixer_sync)
        else $error("mixer sync pulse missing");
    nco_strobe_a: assert property ($rose(sync_strobe) |-> ##2 nco_accum_sync)
        else $error("nco sync pulse missing");
    freq_upper_a: assert property (commit && paddr == 8'h50 |-> ##2 nco_freq_word_ab[31:16] == $past(pwdata[15:0], 2))
        else $error("upper frequency half wrong");
    alarm_clear_a: assert property (clear_s |=> !alarm_out)
        else $error("alarm pin still active after clear");
    soft_sync_a: assert property (commit && paddr == 8'h7c && pwdata[1] && !sw_q |=> qmc_offset_sync && qmc_corr_sync)
        else $error("software sync pulses missing");
endmodule

bind dsc_config_regs dsc_config_props #(.ADDR_W(ADDR_W)) i_props (.*);

/* testbench/dsc_host_model.sv */
/* dsc_host_model: apb master standing in for the host controller.
 * Assumes tb calls its tasks; shares core_clk with the device. */
`timescale 1ns/1ns
module dsc_host_model (
    // clock
    input  wire logic        core_clk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // one transfer, held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [15:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~pwdata; // released data no longer shows the old word
    endtask

    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, idx, d, rd, err);
    endtask
endmodule

/* testbench/tb.sv */
/* tb: start-up sequence, strobe sync, alarm and refusal scenarios.
 * Assumes dsc_config_regs answers apb with one access cycle. */
`timescale 1ns/1ns
module tb;
    import dsc_pkg::*;
    logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, transmit_gate, err;
    logic        alarm_out, tx_active, output_mute;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, nco_freq_word_ab;
    logic [2:0]  lanes;
    logic [8:0]  sync_vec;
    logic [15:0] alarm_events, feature_control, current_control;
    logic [2:0]  pll_loop_voltage;
    int          n_mismatch = 0;
    int          checks = 0;
    // start-up writes and the auto-sync pulse each must raise
    logic [5:0]  s_idx [20] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h07, 6'h08, 6'h09, 6'h0c, 6'h0d,
        6'h10, 6'h12, 6'h14, 6'h15, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1e, 6'h1f, 6'h20};
    logic [15:0] s_dat [20] = '{16'ha19e, 16'h040e, 16'hf052, 16'ha000, 16'hd8ff, 16'h0123,
        16'h8000, 16'h0400, 16'h0400, 16'h3045, 16'h0010, 16'h2000, 16'h0000, 16'h2c67,
        16'h20f4, 16'hec00, 16'h0800, 16'h9191, 16'h4140, 16'h2400};
    logic [8:0]  s_msk [20] = '{0, 0, 0, 0, 0, 9'h100, 0, 0, 0, 9'h080, 9'h040, 0, 0, 0, 0, 0,
        0, 0, 0, 0};

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    dsc_config_regs #(.ADDR_W(8)) i_dut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .transmit_gate, .sync_strobe(lanes[0]),
        .frame_strobe(lanes[1]), .divider_output_strobe(lanes[2]), .alarm_events,
        .pll_loop_voltage, .qmc_offset_sync(sync_vec[8]), .qmc_corr_sync(sync_vec[7]),
        .nco_mixer_sync(sync_vec[6]), .nco_accum_sync(sync_vec[5]),
        .formatter_sync(sync_vec[4]), .fifo_in_ptr_sync(sync_vec[3]),
        .fifo_out_ptr_sync(sync_vec[2]), .clkdiv_sync(sync_vec[1]),
        .pll_ndiv_sync(sync_vec[0]), .nco_freq_word_ab, .feature_control, .current_control,
        .alarm_out, .tx_active, .output_mute);
    dsc_host_model i_host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);

    task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        cmp_word(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
        i_host.xfer(1'b0, idx, 16'h0000, rd, err);
        cmp_word("read data", exp, rd);
    endtask

    task automatic done(input string name);
        $display("test %s finished, %0d mismatches so far", name, n_mismatch);
    endtask

    // one strobe rise; pulses of the six strobe-driven paths two edges later
    task automatic strobe_chk(input int lane, input logic [5:0] exp);
        @(posedge core_clk);
        lanes <= 3'b001 << lane;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        cmp_word("strobe sync pulses", {26'h0, exp}, {26'h0, sync_vec[5:0]});
        @(posedge core_clk);
        lanes <= 3'b000;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic t_startup();
        rd_chk(6'h00, 32'h0000_049c);
        rd_chk(6'h07, 32'h0000_ffff);
        rd_chk(6'h09, 32'h0000_8000);
        for (int i = 0; i < 20; i++) begin
            i_host.wr(s_idx[i], s_dat[i]);
            @(negedge core_clk);
            if (s_msk[i] != 0) cmp_word("auto sync", {23'h0, s_msk[i]}, {23'h0, sync_vec & s_msk[i]});
        end
        cmp_word("frequency word", 32'h2000_0000, nco_freq_word_ab);
        cmp_word("feature control", 32'h0000_a19e, {16'h0, feature_control});
        cmp_word("current control", 32'h0000_a000, {16'h0, current_control});
        done("startup");
    endtask

    task automatic t_strobes(input logic on);
        strobe_chk(0, on ? 6'h21 : 6'h20);
        strobe_chk(1, on ? 6'h18 : 6'h00);
        strobe_chk(2, on ? 6'h06 : 6'h00);
        done("strobes");
    endtask

    task automatic t_alarms();
        rd_chk(6'h18, 32'h0000_2c65);
        @(posedge core_clk);
        alarm_events <= 16'h2000;
        @(posedge core_clk);
        alarm_events <= 16'h0000;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        cmp_bit("alarm output", 1'b1, alarm_out);
        cmp_bit("output mute", 1'b1, output_mute);
        rd_chk(6'h05, 32'h0000_2000);
        i_host.wr(6'h05, 16'h0000);
        rd_chk(6'h05, 32'h0000_0000);
        @(negedge core_clk);
        cmp_bit("alarm output", 1'b0, alarm_out);
        i_host.xfer(1'b0, 6'h04, 16'h0000, rd, err);
        cmp_bit("error response", 1'b1, err);
        cmp_word("refused read data", 32'h0, rd);
        done("alarms");
    endtask

    task automatic t_finish();
        i_host.wr(6'h1f, 16'h4142);
        @(negedge core_clk);
        cmp_word("software sync", 32'h180, {23'h0, sync_vec & 9'h180});
        i_host.wr(6'h00, 16'ha19a);
        i_host.wr(6'h1f, 16'h4148);
        i_host.wr(6'h20, 16'h0000);
        i_host.wr(6'h18, 16'h2467);
        @(posedge core_clk);
        transmit_gate <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        cmp_bit("output mute", 1'b0, output_mute);
        cmp_bit("transmit active", 1'b1, tx_active);
        done("finish");
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence; gate low and reset pulse before any write
    initial begin
        arst_n = 1'b0;
        transmit_gate = 1'b0;
        lanes = 3'b000;
        alarm_events = 16'h0000;
        pll_loop_voltage = 3'h5;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        t_startup();
        t_strobes(1'b1);
        t_alarms();
        t_finish();
        t_strobes(1'b0);
        end_of_test();
    end

    // hang guard, well past the run length
    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
endmodule
